// File: rtl/e3lr_cfg.svh
// Offsets, field positions, reset values and counts for the E3 receiver block
`ifndef E3LR_CFG_SVH
`define E3LR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses of 32-bit words
`define E3LR_OFS_CTRL      4'h0
`define E3LR_OFS_STAT      4'h4
`define E3LR_OFS_IRQ       4'h8
`define E3LR_OFS_MASK      4'hc
`define E3LR_ADDR_HI_ZERO  28'h0000000

// Control register fields
`define E3LR_CTRL_W        4
`define E3LR_BIT_EQBYP     0
`define E3LR_BIT_THR_HI    2
`define E3LR_BIT_THR_LO    1
`define E3LR_BIT_FLOAT_N   3
`define E3LR_CTRL_RST      4'h8

// Status, event and mask fields
`define E3LR_EV_W          2
`define E3LR_BIT_LOS       0
`define E3LR_BIT_LOL       1
`define E3LR_EV_RST        2'h0

// AXI answers
`define E3LR_RESP_OKAY     2'h0
`define E3LR_RESP_DECERR   2'h3

////////////////////////////////////////////////////////////////////////////////
// Consecutive zero bits that declare signal loss, per threshold setting
`define E3LR_LOS_ZEROS_GND 8'h20
`define E3LR_LOS_ZEROS_MID 8'h40
`define E3LR_LOS_ZEROS_VDD 8'h80
`define E3LR_CNT_MAX       8'hff

// Lock check: line edges counted against this many reference edges
`define E3LR_LOL_WINDOW    8'h40
`define E3LR_LOL_TOL       8'h02

// Nominal reference rate and tolerance expected on the reference clock
`define E3LR_REF_FREQ_KHZ  34368
`define E3LR_REF_TOL_PPM   100
`endif

// File: rtl/e3lr_pkg.sv
// Types shared by the E3 receiver block
package e3lr_pkg;
    // Signal-loss threshold select encodings
    typedef enum logic [1:0] {
        E3LR_THR_GND = 2'h0,
        E3LR_THR_MID = 2'h1,
        E3LR_THR_VDD = 2'h2
    } e3lr_thr_t;
endpackage : e3lr_pkg

// File: rtl/e3lr_lane_if.sv
// Synchronised pin level with its edge pulses
`timescale 1ns/1ps
interface e3lr_lane_if;
    logic level;
    logic rise;
    logic fall;
    modport drv (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface : e3lr_lane_if

// File: rtl/e3lr_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module e3lr_sync (
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    // Pin from outside the clock domain
    input  wire logic  i_pin,
    // Filtered level and edges
    e3lr_lane_if.drv   lane
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic rise_r;
    logic fall_r;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            level_r <= 1'b0;
            rise_r  <= 1'b0;
            fall_r  <= 1'b0;
        end else begin
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            if (s2_r == s3_r && s3_r != level_r) begin
                level_r <= s3_r;
                rise_r  <= s3_r;
                fall_r  <= ~s3_r;
            end
        end
    end

    assign lane.level = level_r;
    assign lane.rise  = rise_r;
    assign lane.fall  = fall_r;
endmodule : e3lr_sync

// File: rtl/e3lr_top.sv
// E3 receiver output side: dual rails, recovered clock, alarms, AXI4-Lite registers
`timescale 1ns/1ps
`include "e3lr_cfg.svh"
module e3lr_top (
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    // AXI4-Lite write channels
    input  wire logic [31:0] I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    // AXI4-Lite read channels
    input  wire logic [31:0] I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    // Sliced line from the analog front end
    input  wire logic        I_LINE_CLK,
    input  wire logic        I_LINE_POS,
    input  wire logic        I_LINE_NEG,
    input  wire logic        I_REFERENCE_CLOCK_IN,
    // Terminal equipment side
    output logic             O_RCLK,
    output logic             O_RX_POSITIVE_RAIL,
    output logic             O_RX_NEGATIVE_RAIL,
    output logic             O_RX_SIGNAL_LOST_FLAG,
    output logic             O_PLL_LOCK_LOST_FLAG,
    output logic             O_OUT_OE,
    // Analog front-end controls
    output logic             O_EQUALIZER_BYPASS,
    output logic [1:0]       O_SIGNAL_LOSS_THRESHOLD_SEL,
    // Interrupt
    output logic             O_IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    e3lr_lane_if lclk ();
    e3lr_lane_if lpos ();
    e3lr_lane_if lneg ();
    e3lr_lane_if lref ();

    e3lr_sync u_sync_clk (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_LINE_CLK), .lane(lclk));
    e3lr_sync u_sync_pos (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_LINE_POS), .lane(lpos));
    e3lr_sync u_sync_neg (.i_clk(I_CLK), .i_rst(I_RST), .i_pin(I_LINE_NEG), .lane(lneg));
    e3lr_sync u_sync_ref (.i_clk(I_CLK), .i_rst(I_RST),
                          .i_pin(I_REFERENCE_CLOCK_IN), .lane(lref));

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [`E3LR_CTRL_W-1:0] ctrl_r;
    logic [`E3LR_EV_W-1:0]   irq_r;
    logic [`E3LR_EV_W-1:0]   irq_nxt;
    logic [`E3LR_EV_W-1:0]   mask_r;
    logic [`E3LR_EV_W-1:0]   ev;
    logic                    los_r;
    logic                    lol_r;
    logic                    los_d_r;
    logic                    lol_d_r;
    e3lr_pkg::e3lr_thr_t     thr_sel;
    logic [7:0]              thr;

    assign thr_sel = e3lr_pkg::e3lr_thr_t'(ctrl_r[`E3LR_BIT_THR_HI:`E3LR_BIT_THR_LO]);

    // Threshold count per select setting; the unused code acts as full supply
    always_comb begin
        case (thr_sel)
            e3lr_pkg::E3LR_THR_GND: thr = `E3LR_LOS_ZEROS_GND;
            e3lr_pkg::E3LR_THR_MID: thr = `E3LR_LOS_ZEROS_MID;
            default:                thr = `E3LR_LOS_ZEROS_VDD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data may arrive in either order
    logic        awready_r;
    logic        wready_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [31:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        aw_fire;
    logic        w_fire;
    logic        do_wr;
    logic [31:0] wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        wmap;
    logic        aw_got_nxt;
    logic        w_got_nxt;
    logic        bvalid_nxt;

    assign aw_fire = I_AWVALID & awready_r;
    assign w_fire  = I_WVALID & wready_r;
    assign wa      = aw_got_r ? aw_addr_r : I_AWADDR;
    assign wd      = w_got_r ? w_data_r : I_WDATA;
    assign ws      = w_got_r ? w_strb_r : I_WSTRB;
    assign do_wr   = (aw_got_r | aw_fire) & (w_got_r | w_fire) & ~bvalid_r;
    assign wmap    = (wa[31:4] == `E3LR_ADDR_HI_ZERO);

    // Next state of the write handshake
    always_comb begin
        aw_got_nxt = (aw_got_r | aw_fire) & ~do_wr;
        w_got_nxt  = (w_got_r | w_fire) & ~do_wr;
        bvalid_nxt = do_wr | (bvalid_r & ~I_BREADY);
    end

    // Write handshake registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `E3LR_RESP_OKAY;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= 32'h00000000;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
        end else begin
            aw_got_r  <= aw_got_nxt;
            w_got_r   <= w_got_nxt;
            bvalid_r  <= bvalid_nxt;
            awready_r <= ~aw_got_nxt & ~bvalid_nxt;
            wready_r  <= ~w_got_nxt & ~bvalid_nxt;
            if (aw_fire) begin
                aw_addr_r <= I_AWADDR;
            end
            if (w_fire) begin
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
            end
            if (do_wr) begin
                bresp_r <= wmap ? `E3LR_RESP_OKAY : `E3LR_RESP_DECERR;
            end
        end
    end

    // Control register; float control resets high so outputs drive
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ctrl_r <= `E3LR_CTRL_RST;
        end else if (do_wr && wmap && ws[0] && wa[3:0] == `E3LR_OFS_CTRL) begin
            ctrl_r <= wd[`E3LR_CTRL_W-1:0];
        end
    end

    // Mask register
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            mask_r <= `E3LR_EV_RST;
        end else if (do_wr && wmap && ws[0] && wa[3:0] == `E3LR_OFS_MASK) begin
            mask_r <= wd[`E3LR_EV_W-1:0];
        end
    end

    // Sticky events, write one to clear; a new event wins over the clear
    always_comb begin
        ev = `E3LR_EV_RST;
        ev[`E3LR_BIT_LOS] = los_r & ~los_d_r;
        ev[`E3LR_BIT_LOL] = lol_r & ~lol_d_r;
        irq_nxt = irq_r | ev;
        if (do_wr && wmap && ws[0] && wa[3:0] == `E3LR_OFS_IRQ) begin
            irq_nxt = (irq_r & ~wd[`E3LR_EV_W-1:0]) | ev;
        end
    end

    // Interrupt state and registered output
    logic irq_out_r;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            irq_r     <= `E3LR_EV_RST;
            los_d_r   <= 1'b0;
            lol_d_r   <= 1'b1; // Lock flag starts high; that is no event
            irq_out_r <= 1'b0;
        end else begin
            irq_r     <= irq_nxt;
            los_d_r   <= los_r;
            lol_d_r   <= lol_r;
            irq_out_r <= |(irq_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, data one cycle after the address is taken
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        ar_fire;
    logic        rvalid_nxt;
    logic [31:0] rd_word;
    logic        rmap;

    assign ar_fire    = I_ARVALID & arready_r;
    assign rvalid_nxt = ar_fire | (rvalid_r & ~I_RREADY);
    assign rmap       = (I_ARADDR[31:4] == `E3LR_ADDR_HI_ZERO);

    // Read multiplexer; unused bits read as zero
    always_comb begin
        rd_word = 32'h00000000;
        case (I_ARADDR[3:0])
            `E3LR_OFS_CTRL: rd_word[`E3LR_CTRL_W-1:0] = ctrl_r;
            `E3LR_OFS_STAT: begin
                rd_word[`E3LR_BIT_LOS] = los_r;
                rd_word[`E3LR_BIT_LOL] = lol_r;
            end
            `E3LR_OFS_IRQ:  rd_word[`E3LR_EV_W-1:0] = irq_r;
            `E3LR_OFS_MASK: rd_word[`E3LR_EV_W-1:0] = mask_r;
            default:        rd_word = 32'h00000000;
        endcase
    end

    // Read handshake registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `E3LR_RESP_OKAY;
        end else begin
            rvalid_r  <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_fire) begin
                rdata_r <= rmap ? rd_word : 32'h00000000;
                rresp_r <= rmap ? `E3LR_RESP_OKAY : `E3LR_RESP_DECERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line data: marks caught at recovered rise, rails driven at its fall
    logic cap_pos_r;
    logic cap_neg_r;
    logic rail_pos_r;
    logic rail_neg_r;
    logic rclk_r;
    logic mark;

    assign mark = lpos.level | lneg.level;

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cap_pos_r  <= 1'b0;
            cap_neg_r  <= 1'b0;
            rail_pos_r <= 1'b0;
            rail_neg_r <= 1'b0;
            rclk_r     <= 1'b0;
        end else begin
            rclk_r <= lclk.level;
            if (lclk.rise) begin
                cap_pos_r <= lpos.level;
                cap_neg_r <= lneg.level;
            end
            if (lclk.fall) begin
                rail_pos_r <= cap_pos_r;
                rail_neg_r <= cap_neg_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Signal loss: a run of zero bits at the chosen threshold
    logic [7:0] zcnt_r;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            zcnt_r <= 8'h00;
            los_r  <= 1'b0;
        end else if (lclk.rise) begin
            if (mark) begin
                zcnt_r <= 8'h00;
                los_r  <= 1'b0;
            end else begin
                if (zcnt_r != `E3LR_CNT_MAX) begin
                    zcnt_r <= zcnt_r + 8'h01;
                end
                if (zcnt_r + 8'h01 >= thr) begin
                    los_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lock check: line edges per window of reference edges
    logic [7:0] wcnt_r;
    logic [7:0] lcnt_r;
    logic [7:0] lcnt_eff;
    logic       win_end;

    assign lcnt_eff = (lclk.rise && lcnt_r != `E3LR_CNT_MAX) ? lcnt_r + 8'h01 : lcnt_r;
    assign win_end  = lref.rise && (wcnt_r == `E3LR_LOL_WINDOW - 8'h01);

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wcnt_r <= 8'h00;
            lcnt_r <= 8'h00;
            lol_r  <= 1'b1;
        end else if (win_end) begin
            wcnt_r <= 8'h00;
            lcnt_r <= 8'h00;
            lol_r  <= (lcnt_eff > `E3LR_LOL_WINDOW + `E3LR_LOL_TOL) ||
                      (lcnt_eff < `E3LR_LOL_WINDOW - `E3LR_LOL_TOL);
        end else begin
            lcnt_r <= lcnt_eff;
            if (lref.rise) begin
                wcnt_r <= wcnt_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output enable and front-end controls, all registered
    logic oe_r;
    logic eqbyp_r;
    logic [1:0] thr_out_r;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            oe_r      <= 1'b0;
            eqbyp_r   <= 1'b0;
            thr_out_r <= 2'h0;
        end else begin
            oe_r      <= ctrl_r[`E3LR_BIT_FLOAT_N];
            eqbyp_r   <= ctrl_r[`E3LR_BIT_EQBYP];
            thr_out_r <= thr_sel;
        end
    end

    // Port drive
    assign O_AWREADY = awready_r;
    assign O_WREADY  = wready_r;
    assign O_BVALID  = bvalid_r;
    assign O_BRESP   = bresp_r;
    assign O_ARREADY = arready_r;
    assign O_RVALID  = rvalid_r;
    assign O_RDATA   = rdata_r;
    assign O_RRESP   = rresp_r;
    assign O_RCLK                = rclk_r;
    assign O_RX_POSITIVE_RAIL    = rail_pos_r;
    assign O_RX_NEGATIVE_RAIL    = rail_neg_r;
    assign O_RX_SIGNAL_LOST_FLAG = los_r;
    assign O_PLL_LOCK_LOST_FLAG  = lol_r;
    assign O_OUT_OE              = oe_r;
    assign O_EQUALIZER_BYPASS          = eqbyp_r;
    assign O_SIGNAL_LOSS_THRESHOLD_SEL = thr_out_r;
    assign O_IRQ                       = irq_out_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    sequence s_pos_bit;
        (lclk.rise && lpos.level) ##1 (!lclk.rise && !lclk.fall)[*3] ##1 lclk.fall;
    endsequence
    sequence s_neg_bit;
        (lclk.rise && lneg.level) ##1 (!lclk.rise && !lclk.fall)[*3] ##1 lclk.fall;
    endsequence

    a_pos_rail_mark: assert property (s_pos_bit |=> rail_pos_r)
        else $error("positive mark missing on positive rail");
    a_neg_rail_mark: assert property (s_neg_bit |=> rail_neg_r)
        else $error("negative mark missing on negative rail");
    a_rail_on_fall: assert property ($changed(rail_pos_r) |-> $fell(rclk_r))
        else $error("positive rail moved away from clock fall");
    a_rclk_follow: assert property (lclk.rise |=> rclk_r ##1 rclk_r)
        else $error("recovered clock did not follow line clock");
    a_los_set: assert property ((lclk.rise && !mark && zcnt_r + 8'h01 >= thr)
                                |=> los_r)
        else $error("signal lost flag not raised");
    a_los_clear: assert property ((lclk.rise && mark) |=> !los_r)
        else $error("signal lost flag not cleared on mark");
    a_lol_hold: assert property (!win_end |=> $stable(lol_r))
        else $error("lock flag moved outside window end");
    a_lol_far: assert property ((win_end && lcnt_eff < `E3LR_LOL_WINDOW - `E3LR_LOL_TOL)
                                |=> lol_r)
        else $error("lock flag not raised on slow line clock");
    a_float_oe: assert property (!ctrl_r[`E3LR_BIT_FLOAT_N] |=> !O_OUT_OE)
        else $error("outputs not floated");
    a_eq_bypass: assert property ($changed(ctrl_r[`E3LR_BIT_EQBYP])
                                  |=> O_EQUALIZER_BYPASS == $past(ctrl_r[`E3LR_BIT_EQBYP]))
        else $error("equalizer bypass not forwarded");
    a_thr_mid: assert property (thr_sel == e3lr_pkg::E3LR_THR_MID
                                |-> thr == `E3LR_LOS_ZEROS_MID)
        else $error("mid threshold count wrong");
    a_irq_sticky: assert property ($rose(los_r) |=> irq_r[`E3LR_BIT_LOS])
        else $error("signal loss event not latched");
endmodule : e3lr_top

// File: dv/e3lr_line_model.sv
// Far-side model: recovered line clock, sliced marks and reference clock
`timescale 1ns/1ps
module e3lr_line_model (
    // Line towards the receiver
    output logic o_line_clk,
    output logic o_line_pos,
    output logic o_line_neg,
    // Reference clock
    output logic o_ref_clk
);
    ////////////////////////////////////////////////////////////////////////////
    // Line clock stands low between bursts
    initial begin
        o_line_clk = 1'b0;
        o_line_pos = 1'b0;
        o_line_neg = 1'b0;
    end

    // Continuous reference at the scaled line rate, phase unrelated to the system clock
    initial begin
        o_ref_clk = 1'b0;
        #7;
        forever #160 o_ref_clk = ~o_ref_clk;
    end

    // Test mode controls stay grounded; none are brought out

    ////////////////////////////////////////////////////////////////////////////
    // One bit period: marks set in the low half and held across the rise
    task automatic send_bit(input logic p, input logic n);
        o_line_pos = p;
        o_line_neg = n;
        #160 o_line_clk = 1'b1;
        #160 o_line_clk = 1'b0;
        // Stale marks are inverted so nothing can lean on a held value
        o_line_pos = ~p;
        o_line_neg = ~n;
    endtask : send_bit
endmodule : e3lr_line_model

// File: dv/e3lr_top_bench.sv
// Self-checking bench for the E3 receiver output block
`timescale 1ns/1ps
`include "e3lr_cfg.svh"
module e3lr_top_bench;
    localparam logic [31:0] a_ctrl = {28'h0, `E3LR_OFS_CTRL};
    localparam logic [31:0] a_stat = {28'h0, `E3LR_OFS_STAT};
    localparam logic [31:0] a_irq  = {28'h0, `E3LR_OFS_IRQ};
    localparam logic [31:0] a_mask = {28'h0, `E3LR_OFS_MASK};
    localparam logic [1:0]  ok     = `E3LR_RESP_OKAY;
    localparam logic [1:0]  dec    = `E3LR_RESP_DECERR;
    logic        clk, rst, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv;
    logic [31:0] awa, wd, ara, rd;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp, thr;
    logic        lclk, lpos, lneg, rclk_in, rclk, prail, nrail, los, lol, oe, byp, irq;
    logic        rclk_q, line_on, line_busy;
    logic [7:0]  lfsr_r;
    logic [1:0]  exp_q[$];
    int          err_total, num_checks, bits_sent, falls_seen, k;

    e3lr_top e3lr_top_i (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
        .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wr),
        .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(ara), .I_ARVALID(arv),
        .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy),
        .I_LINE_CLK(lclk), .I_LINE_POS(lpos), .I_LINE_NEG(lneg),
        .I_REFERENCE_CLOCK_IN(rclk_in), .O_RCLK(rclk), .O_RX_POSITIVE_RAIL(prail),
        .O_RX_NEGATIVE_RAIL(nrail), .O_RX_SIGNAL_LOST_FLAG(los), .O_PLL_LOCK_LOST_FLAG(lol),
        .O_OUT_OE(oe), .O_EQUALIZER_BYPASS(byp), .O_SIGNAL_LOSS_THRESHOLD_SEL(thr),
        .O_IRQ(irq));
    e3lr_line_model e3lr_line_model_i (.o_line_clk(lclk), .o_line_pos(lpos),
        .o_line_neg(lneg), .o_ref_clk(rclk_in));

    ////////////////////////////////////////////////////////////////////////////
    // System clock, 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    // Zero run that declares signal loss for a threshold setting
    function automatic int los_zeros(input logic [1:0] t);
        if (t == 2'h0) return int'(`E3LR_LOS_ZEROS_GND);
        if (t == 2'h1) return int'(`E3LR_LOS_ZEROS_MID);
        return int'(`E3LR_LOS_ZEROS_VDD);
    endfunction : los_zeros

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tmo();
        err_total++;
        stop_test();
    endtask : tmo

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write, response compared with the expected code
    task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        awa  <= a;
        wd   <= d;
        awv  <= 1'b1;
        wv   <= 1'b1;
        brdy <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (bv === 1'b1) break;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end
        brdy <= 1'b0;
        if (n == 40) tmo();
        chk(32'(bresp), 32'(er));
        @(posedge clk); // Let bready settle low before the next request
    endtask : axw

    // AXI4-Lite read, masked data and response compared
    task automatic axr(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                       input logic [1:0] er);
        int n;
        ara  <= a;
        arv  <= 1'b1;
        rrdy <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (rv === 1'b1) break;
            if (arr === 1'b1) arv <= 1'b0;
        end
        rrdy <= 1'b0;
        if (n == 40) tmo();
        chk(rd & m, e);
        chk(32'(rresp), 32'(er));
        @(posedge clk); // Let rready settle low before the next request
    endtask : axr

    // Line bits, remembered for the rail monitor
    task automatic line_bit(input logic p, input logic n);
        exp_q.push_back({p, n});
        bits_sent++;
        e3lr_line_model_i.send_bit(p, n);
    endtask : line_bit

    task automatic burst(input logic p, input logic n, input int cnt);
        #13;
        repeat (cnt) line_bit(p, n);
    endtask : burst

    ////////////////////////////////////////////////////////////////////////////
    // Random line traffic while enabled
    always begin
        if (line_on) begin
            line_busy = 1'b1;
            lfsr_r = lfsr_next(lfsr_r);
            line_bit(lfsr_r[0], lfsr_r[1]);
            line_busy = 1'b0;
        end else begin
            @(posedge clk);
            #13;
        end
    end

    // Rails compared with the sent marks at each falling recovered clock
    always @(negedge clk) begin
        if (rclk_q === 1'b1 && rclk === 1'b0) begin
            falls_seen++;
            chk({30'h0, prail, nrail}, {30'h0, exp_q.pop_front()});
        end
        rclk_q <= rclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {awv, wv, brdy, arv, rrdy, rclk_q, line_on, line_busy} = 8'h00;
        {awa, wd, ara} = {32'h0, 32'h0, 32'h0};
        ws = 4'hf;
        rst = 1'b1;
        lfsr_r = 8'h61;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(oe), 32'h1);
        chk(32'(lol), 32'h1);
        axr(a_ctrl, 32'hffffffff, 32'h8, ok);
        axr(a_mask, 32'hffffffff, 32'h0, ok);
        axr(a_irq, 32'hffffffff, 32'h0, ok);
        axr(32'h10, 32'hffffffff, 32'h0, dec);
        axw(32'h10, 32'h0, dec);
        axr(a_ctrl, 32'hffffffff, 32'h8, ok);
        // Every bypass and threshold combination except the unused threshold code 3
        for (int t = 0; t < 3; t++) begin
            for (int b = 0; b < 2; b++) begin
                axw(a_ctrl, {28'h0, 1'b1, 2'(t), 1'(b)}, ok);
                repeat (2) @(posedge clk);
                chk(32'(byp), 32'(b));
                chk(32'(thr), 32'(t));
                axr(a_ctrl, 32'hf, {28'h0, 1'b1, 2'(t), 1'(b)}, ok);
            end
        end
        ws <= 4'he;
        axw(a_ctrl, 32'h0, ok);
        ws <= 4'hf;
        axr(a_ctrl, 32'hf, 32'hd, ok);
        axw(a_ctrl, 32'h0, ok);
        repeat (2) @(posedge clk);
        chk(32'(oe), 32'h0);
        axw(a_ctrl, 32'h8, ok);
        repeat (2) @(posedge clk);
        chk(32'(oe), 32'h1);
        // Random traffic holds lock; stopping the line loses it
        line_on = 1'b1;
        repeat (1600) @(posedge clk);
        chk(32'(lol), 32'h0);
        line_on = 1'b0;
        for (k = 0; k < 40 && line_busy; k++) @(posedge clk);
        if (k == 40) tmo();
        repeat (20) @(posedge clk);
        chk(32'(falls_seen), 32'(bits_sent));
        repeat (1600) @(posedge clk);
        chk(32'(lol), 32'h1);
        axr(a_stat, 32'h2, 32'h2, ok);
        axr(a_irq, 32'h3, 32'h2, ok);
        axw(a_irq, 32'h3, ok);
        axr(a_irq, 32'h3, 32'h0, ok);
        // Signal loss at each threshold, event latched and cleared; interrupt raised at the first threshold only, then masked
        axw(a_mask, 32'h1, ok);
        for (int t = 0; t < 3; t++) begin
            axw(a_ctrl, {28'h0, 1'b1, 2'(t), 1'b0}, ok);
            burst(1'b1, 1'b0, 1);
            burst(1'b0, 1'b0, los_zeros(2'(t)) - 1);
            repeat (10) @(posedge clk);
            chk(32'(los), 32'h0);
            burst(1'b0, 1'b0, 1);
            repeat (10) @(posedge clk);
            chk(32'(los), 32'h1);
            chk(32'(irq), (t == 0) ? 32'h1 : 32'h0);
            axr(a_irq, 32'h1, 32'h1, ok);
            axw(a_irq, 32'h1, ok);
            axw(a_mask, 32'h0, ok);
            repeat (3) @(posedge clk);
            chk(32'(irq), 32'h0);
            burst(1'b0, 1'b1, 1);
            repeat (10) @(posedge clk);
            chk(32'(los), 32'h0);
        end
        chk(32'(exp_q.size()), 32'h0);
        stop_test();
    end
endmodule : e3lr_top_bench
